// File: core/fbsc_regs.sv
// Register slice: reduction status per channel and boost mode and voltage control
`timescale 1ns/1ps
module fbsc_regs
  import fbsc_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Register port from the serial slave
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  // Reduction events from the current control
  input  wire logic       led1Reduction,
  input  wire logic       led2Reduction,
  input  wire logic       flashMode,
  input  wire logic [5:0] led1Current,
  input  wire logic [5:0] led2Current,
  // Boost controls
  output logic      [2:0] boostMode,
  output logic            boostOn,
  output logic            led1Adaptive,
  output logic            led2Adaptive,
  output logic            boostFixed,
  output logic            dualChannelSelect,
  output logic      [9:0] ledCurrentLimitMa,
  output logic      [6:0] boostVoltageCode,
  output logic      [6:0] boostVoltageStep,
  output logic     [12:0] boostVoltageMv
);
  import fbsc_pkg::*;

  // Redundant codes fold onto one step index, none rejected
  function automatic logic [6:0] fbsc_vstep(input logic [6:0] code);
    if (code <= VCODE_FLOOR) fbsc_vstep = 7'h00;
    else if (code >= VCODE_CEIL) fbsc_vstep = VSTEP_MAX;
    else fbsc_vstep = code - VCODE_FLOOR;
  endfunction

  logic [7:0] mode_ff, nxt_mode;
  logic [6:0] vcode_ff, nxt_vcode;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [5:0] low1, low2;
  logic       fl1, fl2;
  logic       wr1, wr2;
  logic [6:0] stepNow;

  assign wr1 = regWrite && (regAddr == ADDR_STAT_LED1);
  assign wr2 = regWrite && (regAddr == ADDR_STAT_LED2);

  fbsc_min_tracker uLed1 (
    .mclk             (mclk),
    .sys_rst          (sys_rst),
    .reductionActive  (led1Reduction),
    .flashMode        (flashMode),
    .ledCurrent       (led1Current),
    .swWrite          (wr1),
    .swData           (regWdata),
    .lowestCurrent    (low1),
    .reductionInFlash (fl1)
  );

  fbsc_min_tracker uLed2 (
    .mclk             (mclk),
    .sys_rst          (sys_rst),
    .reductionActive  (led2Reduction),
    .flashMode        (flashMode),
    .ledCurrent       (led2Current),
    .swWrite          (wr2),
    .swData           (regWdata),
    .lowestCurrent    (low2),
    .reductionInFlash (fl2)
  );

  always_comb begin
    nxt_mode  = mode_ff;
    nxt_vcode = vcode_ff;
    if (regWrite && regAddr == ADDR_BOOST_MODE) begin
      // Reserved bits 6:3 kept at zero; codes 101-111 are software's to avoid
      nxt_mode = {regWdata[DUAL_BIT], 4'h0, regWdata[2:0]};
    end
    if (regWrite && regAddr == ADDR_BOOST_VOUT) begin
      nxt_vcode = regWdata[6:0];
    end
    case (regAddr)
      ADDR_STAT_LED1:  nxt_rdata = {fl1, 1'b0, low1};
      ADDR_STAT_LED2:  nxt_rdata = {fl2, 1'b0, low2};
      ADDR_BOOST_MODE: nxt_rdata = mode_ff;
      ADDR_BOOST_VOUT: nxt_rdata = {1'b0, vcode_ff};
      default:         nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_ff  <= RST_REG;
      vcode_ff <= 7'h00;
      rdata_ff <= 8'h00;
    end else begin
      mode_ff  <= nxt_mode;
      vcode_ff <= nxt_vcode;
      rdata_ff <= nxt_rdata;
    end
  end

  assign regRdata  = rdata_ff;
  assign boostMode = mode_ff[2:0];
  assign dualChannelSelect = mode_ff[DUAL_BIT];
  assign boostVoltageCode  = vcode_ff;

  always_comb begin
    boostOn      = 1'b1;
    led1Adaptive = 1'b0;
    led2Adaptive = 1'b0;
    boostFixed   = 1'b0;
    case (mode_ff[2:0])
      BM_OFF:       boostOn = 1'b0;
      BM_ADAPT_CH1: led1Adaptive = 1'b1;
      BM_ADAPT_CH2: led2Adaptive = 1'b1;
      BM_ADAPT_ALL: begin
        led1Adaptive = 1'b1;
        led2Adaptive = 1'b1;
      end
      BM_FIXED:     boostFixed = 1'b1;
      default:      boostOn = 1'b0;
    endcase
  end

  // Channel count steers the current ceiling; software keeps it honest
  assign ledCurrentLimitMa = mode_ff[DUAL_BIT] ? ILIM_DUAL : ILIM_SINGLE;

  // Adaptive modes regulate from the LED headroom, the code is not used
  assign stepNow          = fbsc_vstep(vcode_ff);
  assign boostVoltageStep = boostFixed ? stepNow : 7'h00;
  assign boostVoltageMv   = boostFixed ?
      13'(VOUT_MIN_MV) + 13'(stepNow) * 13'(VOUT_STEP_MV) : 13'h0000;

  // Current ceiling follows the channel count
  a_single_limit: assert property (@(posedge mclk) disable iff (sys_rst)
    !dualChannelSelect |-> ledCurrentLimitMa == 10'h3E8)
    else $error("single channel limit wrong");
  a_dual_limit: assert property (@(posedge mclk) disable iff (sys_rst)
    dualChannelSelect |-> ledCurrentLimitMa == 10'h271)
    else $error("dual channel limit wrong");

  // Mode decode, one check per defined code
  a_off_decode: assert property (@(posedge mclk) disable iff (sys_rst)
    boostMode == BM_OFF |-> !boostOn && !led1Adaptive && !led2Adaptive && !boostFixed)
    else $error("off mode decode wrong");
  a_ch1_adapt: assert property (@(posedge mclk) disable iff (sys_rst)
    boostMode == BM_ADAPT_CH1 |-> boostOn && led1Adaptive && !led2Adaptive && !boostFixed)
    else $error("channel 1 adaptive decode wrong");
  a_ch2_adapt: assert property (@(posedge mclk) disable iff (sys_rst)
    boostMode == BM_ADAPT_CH2 |-> boostOn && !led1Adaptive && led2Adaptive && !boostFixed)
    else $error("channel 2 adaptive decode wrong");
  a_both_adapt: assert property (@(posedge mclk) disable iff (sys_rst)
    boostMode == BM_ADAPT_ALL |-> boostOn && led1Adaptive && led2Adaptive && !boostFixed)
    else $error("dual adaptive decode wrong");
  a_fixed_decode: assert property (@(posedge mclk) disable iff (sys_rst)
    boostMode == BM_FIXED |-> boostOn && !led1Adaptive && !led2Adaptive && boostFixed)
    else $error("fixed mode decode wrong");
  a_mode_write: assert property (@(posedge mclk) disable iff (sys_rst)
    regWrite && regAddr == ADDR_BOOST_MODE |=> boostMode == $past(regWdata[2:0])
      && dualChannelSelect == $past(regWdata[DUAL_BIT]))
    else $error("mode write lost");
  a_mode_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    !(regWrite && regAddr == ADDR_BOOST_MODE) |=> $stable(mode_ff))
    else $error("mode changed without a write");

  // Voltage code: ignored when adaptive, folded when fixed
  a_adapt_ignore: assert property (@(posedge mclk) disable iff (sys_rst)
    (led1Adaptive || led2Adaptive) |-> boostVoltageMv == 13'h0000 && !boostFixed)
    else $error("voltage code used in adaptive mode");
  a_adapt_step: assert property (@(posedge mclk) disable iff (sys_rst)
    !boostFixed |-> boostVoltageStep == 7'h00)
    else $error("voltage step shown outside fixed mode");
  a_floor_code: assert property (@(posedge mclk) disable iff (sys_rst)
    boostFixed && vcode_ff <= VCODE_FLOOR |-> boostVoltageMv == 13'hCE4)
    else $error("floor code not 3.3 V");
  a_ceil_code: assert property (@(posedge mclk) disable iff (sys_rst)
    boostFixed && vcode_ff >= VCODE_CEIL |-> boostVoltageMv == 13'h157C)
    else $error("ceiling code not 5.5 V");
  a_linear_step: assert property (@(posedge mclk) disable iff (sys_rst)
    boostFixed && vcode_ff > VCODE_FLOOR && vcode_ff < VCODE_CEIL
      |-> boostVoltageStep == vcode_ff - VCODE_FLOOR)
    else $error("voltage step not linear");
  a_mv_from_step: assert property (@(posedge mclk) disable iff (sys_rst)
    boostFixed |-> boostVoltageMv == 13'hCE4 + 13'h19 * {6'h00, boostVoltageStep})
    else $error("voltage not 25 mV per step");
  a_step_ceiling: assert property (@(posedge mclk) disable iff (sys_rst)
    boostFixed |-> boostVoltageStep <= VSTEP_MAX)
    else $error("voltage step past ceiling");
  a_vout_write: assert property (@(posedge mclk) disable iff (sys_rst)
    regWrite && regAddr == ADDR_BOOST_VOUT |=> boostVoltageCode == $past(regWdata[6:0]))
    else $error("voltage code write lost");
  a_vout_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    !(regWrite && regAddr == ADDR_BOOST_VOUT) |=> $stable(vcode_ff))
    else $error("voltage code changed without a write");

  // Read-back, one cycle after the address
  a_stat_read: assert property (@(posedge mclk) disable iff (sys_rst)
    regAddr == ADDR_STAT_LED1 |=> regRdata[6] == 1'b0 && regRdata[5:0] == $past(low1))
    else $error("channel 1 status read wrong");
  a_stat1_mode: assert property (@(posedge mclk) disable iff (sys_rst)
    regAddr == ADDR_STAT_LED1 |=> regRdata[MODE_BIT] == $past(fl1))
    else $error("channel 1 mode bit read wrong");
  a_stat2_read: assert property (@(posedge mclk) disable iff (sys_rst)
    regAddr == ADDR_STAT_LED2 |=> regRdata[6] == 1'b0 && regRdata[5:0] == $past(low2))
    else $error("channel 2 status read wrong");
  a_stat2_mode: assert property (@(posedge mclk) disable iff (sys_rst)
    regAddr == ADDR_STAT_LED2 |=> regRdata[MODE_BIT] == $past(fl2))
    else $error("channel 2 mode bit read wrong");
  a_mode_read: assert property (@(posedge mclk) disable iff (sys_rst)
    regAddr == ADDR_BOOST_MODE
      |=> regRdata == {$past(dualChannelSelect), 4'h0, $past(boostMode)})
    else $error("mode register read wrong");
  a_vout_read: assert property (@(posedge mclk) disable iff (sys_rst)
    regAddr == ADDR_BOOST_VOUT |=> regRdata == {1'b0, $past(boostVoltageCode)})
    else $error("voltage register read wrong");
endmodule // fbsc_regs

// File: core/fbsc_pkg.sv
// Constants and types for the flash boost status and control register slice
// Overview of operation
// - Channel-1 status bits 5:0 hold the lowest LED current code seen during a reduction event.
// - Channel-1 status bit 7 is 1 when that event happened in flash mode and 0 in torch mode.
// - Channel-2 status bits 5:0 hold the lowest channel-2 current code seen during an event.
// - Channel-2 status bit 7 tells flash mode (1) from torch mode (0) for that event.
// - The 3-bit boost mode decodes to off, ch1 adaptive, ch2 adaptive, both adaptive, fixed.
// - With the channel-count bit at 0 one channel is active and boost current is held to 1 A.
// - With the channel-count bit at 1 both channels are active, 625 mA each.
// - In fixed mode the boost voltage comes from a 7-bit code, 3.3 V to 5.5 V in 25 mV steps.
// - In any adaptive mode the stored voltage code is ignored.
// - Redundant voltage codes are accepted and map to the same voltage.
// - Codes 0x00 to 0x0C give 3.300 V, codes 0x64 and up give 5.500 V, linear between.
package fbsc_pkg;
  localparam logic [7:0] ADDR_STAT_LED1  = 8'h08;
  localparam logic [7:0] ADDR_STAT_LED2  = 8'h09;
  localparam logic [7:0] ADDR_BOOST_MODE = 8'h0A;
  localparam logic [7:0] ADDR_BOOST_VOUT = 8'h0B;
  localparam logic [7:0] RST_REG         = 8'h00;
  localparam int         CUR_MSB         = 5;
  localparam int         MODE_BIT        = 7;
  localparam int         DUAL_BIT        = 7;
  localparam logic [6:0] VCODE_FLOOR     = 7'h0C;
  localparam logic [6:0] VCODE_CEIL      = 7'h64;
  localparam logic [6:0] VSTEP_MAX       = 7'h58;
  localparam logic [5:0] CUR_FULL        = 6'h3F;
  localparam int         VOUT_MIN_MV     = 3300;
  localparam int         VOUT_STEP_MV    = 25;
  localparam int         ILIM_SINGLE_MA  = 1000;
  localparam int         ILIM_DUAL_MA    = 625;
  localparam logic [9:0] ILIM_SINGLE     = 10'(ILIM_SINGLE_MA);
  localparam logic [9:0] ILIM_DUAL       = 10'(ILIM_DUAL_MA);

  typedef enum logic [2:0] {
    BM_OFF       = 3'b000,
    BM_ADAPT_CH1 = 3'b001,
    BM_ADAPT_CH2 = 3'b010,
    BM_ADAPT_ALL = 3'b011,
    BM_FIXED     = 3'b100
  } fbsc_bmode_e;
endpackage

// File: core/fbsc_min_tracker.sv
// Per-channel lowest-current and mode capture during a reduction event
`timescale 1ns/1ps
module fbsc_min_tracker
  import fbsc_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Event side
  input  wire logic       reductionActive,
  input  wire logic       flashMode,
  input  wire logic [5:0] ledCurrent,
  // Software write of the status register
  input  wire logic       swWrite,
  input  wire logic [7:0] swData,
  // Status
  output logic      [5:0] lowestCurrent,
  output logic            reductionInFlash
);
  import fbsc_pkg::*;

  logic [5:0] cur_ff, nxt_cur;
  logic       mode_ff, nxt_mode;
  logic       act_ff, nxt_act;

  always_comb begin
    nxt_cur  = cur_ff;
    nxt_mode = mode_ff;
    nxt_act  = reductionActive;
    if (swWrite) begin
      nxt_cur  = swData[CUR_MSB:0];
      nxt_mode = swData[MODE_BIT];
    end
    // Hardware capture wins over a software write in the same cycle
    if (reductionActive && !act_ff) begin
      nxt_cur  = ledCurrent;
      nxt_mode = flashMode;
    end else if (reductionActive && ledCurrent < cur_ff) begin
      nxt_cur  = ledCurrent;
    end
    // Outside an event the values are held unless software writes them
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff  <= 6'h00;
      mode_ff <= 1'b0;
      act_ff  <= 1'b0;
    end else begin
      cur_ff  <= nxt_cur;
      mode_ff <= nxt_mode;
      act_ff  <= nxt_act;
    end
  end

  assign lowestCurrent    = cur_ff;
  assign reductionInFlash = mode_ff;

  a_hold_after_event: assert property (@(posedge mclk) disable iff (sys_rst)
    !reductionActive && !swWrite |=> $stable(cur_ff) && $stable(mode_ff))
    else $error("status changed outside an event");
  a_start_capture: assert property (@(posedge mclk) disable iff (sys_rst)
    reductionActive && !act_ff |=> cur_ff == $past(ledCurrent) && mode_ff == $past(flashMode))
    else $error("event start not captured");
  a_min_monotone: assert property (@(posedge mclk) disable iff (sys_rst)
    reductionActive && act_ff && !swWrite |=> cur_ff <= $past(cur_ff))
    else $error("lowest current rose during event");
endmodule // fbsc_min_tracker

// File: verification/fbsc_host_model.sv
// Host model that reaches the slice through its register port
`timescale 1ns/1ps
module fbsc_host_model (
  // Clock
  input  wire logic       mclk,
  // Register port
  output logic      [7:0] regAddr,
  output logic            regWrite,
  output logic      [7:0] regWdata,
  // Read data due at the next falling edge
  output logic            rdDone
);
  initial begin
    regAddr  = 8'h00;
    regWrite = 1'b0;
    regWdata = 8'h00;
    rdDone   = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    regAddr  = a;
    // Reserved boost codes never leave the host
    regWdata = (a == 8'h0A && d[2:0] > 3'h4) ? {d[7:3], 3'h0} : d;
    regWrite = 1'b1;
    @(posedge mclk);
    #1;
    regWrite = 1'b0;
    // Stale data must not look valid
    regWdata = ~regWdata;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    #1;
    regAddr = a;
    @(posedge mclk);
    #1;
    rdDone = 1'b1;
    @(posedge mclk);
    #1;
    rdDone = 1'b0;
  endtask
endmodule // fbsc_host_model

// File: verification/test_fbsc_regs.sv
// Self-checking bench for the flash boost status and control register slice
`timescale 1ns/1ps
module test_fbsc_regs;
  logic        mclk, sysRst, regWrite, rdDone, flashMode, red1, red2;
  logic        bOn, a1, a2, bFix, dual;
  logic [5:0]  cur1, cur2;
  logic [2:0]  bMode;
  logic [6:0]  vCode, vStep;
  logic [7:0]  regAddr, regWdata, regRdata;
  logic [9:0]  iLim;
  logic [12:0] vMv;
  logic [7:0]  sh [4];
  logic [52:0] exq [$];
  int          numErrors, numChecks, rnd;
  wire  [52:0] obs = {regRdata, bMode, bOn, a1, a2, bFix, dual, iLim, vCode, vStep, vMv};
  localparam logic [7:0] MSK [4] = '{8'hBF, 8'hBF, 8'h87, 8'h7F};
  localparam logic [7:0] VC [6] = '{8'h0C, 8'h0D, 8'h10, 8'h63, 8'h64, 8'h7F};

  fbsc_regs fbsc_regs_i (
    .mclk(mclk), .sys_rst(sysRst), .regAddr(regAddr), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(regRdata), .led1Reduction(red1), .led2Reduction(red2),
    .flashMode(flashMode), .led1Current(cur1), .led2Current(cur2), .boostMode(bMode),
    .boostOn(bOn), .led1Adaptive(a1), .led2Adaptive(a2), .boostFixed(bFix),
    .dualChannelSelect(dual), .ledCurrentLimitMa(iLim), .boostVoltageCode(vCode),
    .boostVoltageStep(vStep), .boostVoltageMv(vMv)
  );
  fbsc_host_model fbsc_host_model_i (
    .mclk(mclk), .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
    .rdDone(rdDone)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  function automatic logic [52:0] expv(input logic [7:0] a);
    logic [7:0] r;
    logic [2:0] m;
    logic [6:0] c;
    logic [6:0] s;
    logic       fx;
    r  = (a[7:2] == 6'h02) ? (sh[a[1:0]] & MSK[a[1:0]]) : 8'h00;
    m  = sh[2][2:0];
    c  = sh[3][6:0];
    fx = (m == 3'h4);
    s  = (c <= 7'h0C) ? 7'h00 : (c >= 7'h64) ? 7'h58 : c - 7'h0C;
    return {r, m, m != 3'h0 && m < 3'h5, m == 3'h1 || m == 3'h3, m == 3'h2 || m == 3'h3, fx,
            sh[2][7], sh[2][7] ? 10'h271 : 10'h3E8, c, fx ? s : 7'h00,
            fx ? 13'hCE4 + 13'h19 * {6'h00, s} : 13'h0000};
  endfunction

  task automatic check(input string what, input logic [52:0] seen, input logic [52:0] want);
    numChecks++;
    if (seen !== want) begin
      numErrors++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    fbsc_host_model_i.wr(a, d);
    if (a[7:2] == 6'h02) sh[a[1:0]] = d;
  endtask

  task automatic rc(input logic [7:0] a);
    exq.push_back(expv(a));
    fbsc_host_model_i.rd(a);
  endtask

  // Lowest current follows the first sample, then only falls
  task automatic ev(input bit ch, input logic f, input int n);
    logic [5:0] c, lo;
    @(posedge mclk);
    #1;
    flashMode = f;
    for (int i = 0; i < n; i++) begin
      c = 6'($urandom_range(63, 1));
      lo = (i == 0 || c < lo) ? c : lo;
      if (ch) cur2 = c;
      else cur1 = c;
      red1 = !ch;
      red2 = ch;
      @(posedge mclk);
      #1;
    end
    {red1, red2, cur1, cur2} = '0;
    sh[ch] = {f, 1'b0, lo};
  endtask

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(negedge mclk) begin
    if (rdDone) begin
      if (exq.size() == 0) begin
        numErrors++;
        $display("BAD read expected none seen %h", obs);
      end else begin
        check("read", obs, exq.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    numErrors++;
    report_and_stop();
  end

  initial begin
    sysRst = 1'b1;
    {red1, red2, flashMode, cur1, cur2} = '0;
    sh = '{default: 8'h00};
    rnd = $urandom(77);
    repeat (3) @(posedge mclk);
    #1;
    sysRst = 1'b0;
    for (int a = 8; a < 13; a++) rc(8'(a));
    w(8'h08, 8'hFF);
    w(8'h0B, 8'hFF);
    w(8'h0C, 8'h5A);
    for (int a = 8; a < 13; a++) rc(8'(a));
    for (int m = 0; m < 5; m++) begin
      w(8'h0A, {m == 3, 4'h0, 3'(m)});
      w(8'h0B, 8'($urandom_range(127)));
      rc(8'h0A);
    end
    foreach (VC[i]) begin
      w(8'h0B, VC[i]);
      rc(8'h0B);
    end
    w(8'h0A, 8'hFC);
    rc(8'h0A);
    ev(0, 1'b1, 5);
    rc(8'h08);
    ev(1, 1'b1, 4);
    rc(8'h09);
    rc(8'h08);
    ev(0, 1'b0, 3);
    rc(8'h08);
    // Mid-run reset must clear everything written above
    @(posedge mclk);
    #1;
    sysRst = 1'b1;
    sh = '{default: 8'h00};
    @(posedge mclk);
    #1;
    sysRst = 1'b0;
    for (int a = 8; a < 12; a++) rc(8'(a));
    repeat (2) @(posedge mclk);
    report_and_stop();
  end
endmodule // test_fbsc_regs
